/* design/cctc_pkg.sv */
// cctc_pkg: constants and carrier types of the cycle timing block
// assumes one system clock; oscillator ticks arrive as sampled levels
package cctc_pkg;
   // ----------------------------------------
   // register map (word aligned byte offsets)
   // ----------------------------------------
   localparam logic [7:0] CCTC_OFF_CFG = 8'h00;
   localparam logic [7:0] CCTC_OFF_PRE = 8'h04;
   localparam logic [7:0] CCTC_OFF_FULL = 8'h08;
   localparam logic [7:0] CCTC_OFF_DIS = 8'h0C;
   localparam logic [7:0] CCTC_OFF_GAIN = 8'h10;
   localparam logic [7:0] CCTC_OFF_CTRL = 8'h14;
   localparam logic [7:0] CCTC_OFF_STAT = 8'h18;
   localparam logic [7:0] CCTC_OFF_RAW = 8'h1C;
   localparam logic [7:0] CCTC_OFF_COMP = 8'h20;
   localparam logic [7:0] CCTC_OFF_COR = 8'h24;
   // ----------------------------------------
   // cfg and ctrl field positions
   // ----------------------------------------
   localparam int CCTC_CFG_FAST = 0;
   localparam int CCTC_CFG_BYP = 1;
   localparam int CCTC_CFG_FLOAT = 2;
   localparam int CCTC_CFG_DIFF = 3;
   localparam int CCTC_CFG_CINT = 4;
   localparam int CCTC_CFG_CEXT = 5;
   localparam int CCTC_CFG_DCFREE = 6;
   localparam int CCTC_CTRL_START = 0;
   localparam int CCTC_CTRL_CMP = 1;
   // ----------------------------------------
   // reset values and counts
   // ----------------------------------------
   localparam logic [9:0] CCTC_CODE_SKIP = 10'h3FF;
   localparam logic [6:0] CCTC_CFG_RST = 7'h10;
   localparam logic [9:0] CCTC_PRE_RST = 10'h000;
   localparam logic [9:0] CCTC_FULL_RST = 10'h000;
   localparam logic [9:0] CCTC_DIS_RST = 10'h00F;
   localparam logic [15:0] CCTC_GAIN_RST = 16'h0000;
   localparam logic [1:0] CCTC_DIV4_LAST = 2'h3;
   localparam logic [15:0] CCTC_TDC_MAX = 16'hFFFF;

   typedef enum logic [5:0]
   {
      CCTC_IDLE = 6'b000001,
      CCTC_PRE = 6'b000010,
      CCTC_FULL = 6'b000100,
      CCTC_DIS = 6'b001000,
      CCTC_GND = 6'b010000,
      CCTC_NEXT = 6'b100000
   } cctc_state_type;

   // port drive carried as one group
   typedef struct packed
   {
      logic sw_a;
      logic sw_b;
      logic res_pre;
      logic drive_0;
      logic drive_1;
      logic dis_0;
      logic dis_1;
   } cctc_drive_type;
endpackage

/* design/cctc_top.sv */
// cctc_top: cycle timing and compensation control of a cap converter
// assumes AHB-Lite single master; oscillator ticks and comparator
// arrive asynchronous and are synchronised here
//
// Operation
// - every cycle runs pre-charge, full charge (each skipped at code 1023), then timed discharge.
// - no comparator trigger during discharge stops the cycle, no full charge.
// - internal compensation keeps both port switches open.
// - external compensation only acts in floating mode.
// - floating capacitor measured as port 0, port 1, then both.
// - dc-free drive alters port control for differential floating sensors.
// - internal delay is subtracted from each raw measurement.
// - fast select 0 and bypass 0 use the slow oscillator period.
// - fast select 1 uses four fast periods, or one with bypass set.
// - all phases but the first of a cycle last whole cycle time base periods.
// - pre-charge 1023 skips; else code+1, code+2 if fast and full 1023.
// - full charge 1023 skips; else code+1 slow, code+2 fast.
// - discharge gives code+1 slow periods and code periods fast.
`timescale 1ns/1ps
module cctc_top
   import cctc_pkg::*;
#(
   parameter int CODE_W = 10
)
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic slow_oscillator,
   input wire logic fast_oscillator,
   input wire logic comparator,
   output cctc_drive_type port_drive,
   output logic tdc_run,
   output logic cycle_busy
);
   // ----------------------------------------
   // synchronisers and tick detect
   // ----------------------------------------
   logic [1:0] slow_s_reg, fast_s_reg, cmp_s_reg;
   logic slow_d_reg, fast_d_reg;
   logic [1:0] slow_s_next, fast_s_next, cmp_s_next;
   always_comb
   begin
      slow_s_next = {slow_s_reg[0], slow_oscillator};
      fast_s_next = {fast_s_reg[0], fast_oscillator};
      cmp_s_next = {cmp_s_reg[0], comparator};
   end
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         slow_s_reg <= 2'h0;
         fast_s_reg <= 2'h0;
         cmp_s_reg <= 2'h0;
         slow_d_reg <= 1'b0;
         fast_d_reg <= 1'b0;
      end
      else
      begin
         slow_s_reg <= slow_s_next;
         fast_s_reg <= fast_s_next;
         cmp_s_reg <= cmp_s_next;
         slow_d_reg <= slow_s_reg[1];
         fast_d_reg <= fast_s_reg[1];
      end
   end
   wire slow_tick = slow_s_reg[1] & ~slow_d_reg;
   wire fast_tick = fast_s_reg[1] & ~fast_d_reg;
   wire cmp_hit = cmp_s_reg[1];

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [6:0] cfg_reg, cfg_next;
   logic [CODE_W-1:0] pre_reg, pre_next, full_reg, full_next;
   logic [CODE_W-1:0] dis_reg, dis_next;
   logic [15:0] gain_reg, gain_next;
   logic start_reg, start_next;
   logic err_reg, err_next, done_reg, done_next;
   logic [15:0] raw_reg, raw_next, comp_reg, comp_next;
   logic [15:0] cor_reg, cor_next;
   logic wr_pend_reg, wr_pend_next;
   logic [7:0] addr_reg, addr_next;
   logic [31:0] rdata_reg, rdata_next;

   wire fast_sel = cfg_reg[CCTC_CFG_FAST];
   wire floating = cfg_reg[CCTC_CFG_FLOAT];
   wire ext_on = cfg_reg[CCTC_CFG_CEXT] & floating;
   wire dc_free = cfg_reg[CCTC_CFG_DCFREE] & floating
      & cfg_reg[CCTC_CFG_DIFF];

   // ----------------------------------------
   // cycle time base divider
   // ----------------------------------------
   logic [1:0] div_reg, div_next;
   logic base_tick;
   always_comb
   begin
      div_next = div_reg;
      base_tick = 1'b0;
      if (!fast_sel)
         base_tick = slow_tick;
      else if (cfg_reg[CCTC_CFG_BYP])
         base_tick = fast_tick;
      else if (fast_tick)
      begin
         div_next = div_reg + 2'h1;
         base_tick = (div_reg == CCTC_DIV4_LAST);
      end
   end
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         div_reg <= 2'h0;
      else
         div_reg <= div_next;
   end

   // phase lengths in base periods, minus one for the down-counter
   function automatic logic [CODE_W:0] pre_len(input logic [CODE_W-1:0] c);
      pre_len = {1'b0, c};
      if (fast_sel && full_reg == CCTC_CODE_SKIP)
         pre_len = {1'b0, c} + 11'h1;
   endfunction
   function automatic logic [CODE_W:0] full_len(input logic [CODE_W-1:0] c);
      full_len = fast_sel ? {1'b0, c} + 11'h1 : {1'b0, c};
   endfunction

   // ----------------------------------------
   // cycle sequencer
   // ----------------------------------------
   cctc_state_type state_reg, state_next;
   logic [CODE_W:0] cnt_reg, cnt_next;
   logic [1:0] meas_reg, meas_next; // 0 p0, 1 p1, 2 both, 3 internal
   logic [15:0] tdc_reg, tdc_next;
   logic trig_reg, trig_next;
   cctc_drive_type drv;

   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      meas_next = meas_reg;
      tdc_next = tdc_reg;
      trig_next = trig_reg;
      err_next = err_reg;
      done_next = done_reg;
      raw_next = raw_reg;
      comp_next = comp_reg;
      case (state_reg)
         CCTC_IDLE:
         begin
            if (start_reg)
            begin
               meas_next = ext_on ? 2'h0 : 2'h3;
               done_next = 1'b0;
               err_next = 1'b0;
               state_next = CCTC_NEXT;
            end
         end
         CCTC_NEXT:
         begin
            trig_next = 1'b0;
            tdc_next = 16'h0000;
            if (pre_reg != CCTC_CODE_SKIP)
            begin
               cnt_next = pre_len(pre_reg);
               state_next = CCTC_PRE;
            end
            else if (full_reg != CCTC_CODE_SKIP)
            begin
               cnt_next = full_len(full_reg);
               state_next = CCTC_FULL;
            end
            else
            begin
               cnt_next = fast_sel ? {1'b0, dis_reg} - 11'h1
                  : {1'b0, dis_reg};
               state_next = (fast_sel && dis_reg == 10'h000)
                  ? CCTC_GND : CCTC_DIS;
            end
         end
         CCTC_PRE, CCTC_FULL:
         begin
            if (base_tick)
            begin
               if (cnt_reg != 11'h000)
                  cnt_next = cnt_reg - 11'h1;
               else if (state_reg == CCTC_PRE
                  && full_reg != CCTC_CODE_SKIP)
               begin
                  cnt_next = full_len(full_reg);
                  state_next = CCTC_FULL;
               end
               else
               begin
                  cnt_next = fast_sel ? {1'b0, dis_reg} - 11'h1
                     : {1'b0, dis_reg};
                  state_next = (fast_sel && dis_reg == 10'h000)
                     ? CCTC_GND : CCTC_DIS;
               end
            end
         end
         CCTC_DIS:
         begin
            if (!trig_reg && !cmp_hit && tdc_reg != CCTC_TDC_MAX)
               tdc_next = tdc_reg + 16'h1;
            if (cmp_hit)
               trig_next = 1'b1;
            if (base_tick)
            begin
               if (cnt_reg != 11'h000)
                  cnt_next = cnt_reg - 11'h1;
               else
                  state_next = CCTC_GND;
            end
         end
         CCTC_GND:
         begin
            if (!trig_reg)
            begin
               err_next = 1'b1;
               done_next = 1'b1;
               state_next = CCTC_IDLE;
            end
            else
            begin
               if (meas_reg == 2'h3)
                  comp_next = tdc_reg;
               else
                  raw_next = tdc_reg;
               // without internal compensation the floating set ends
               // after both electrodes have been measured
               if (meas_reg == 2'h3
                  || (meas_reg == 2'h2 && !cfg_reg[CCTC_CFG_CINT]))
               begin
                  done_next = 1'b1;
                  state_next = CCTC_IDLE;
               end
               else
               begin
                  meas_next = (meas_reg == 2'h2) ? 2'h3
                     : meas_reg + 2'h1;
                  state_next = CCTC_NEXT;
               end
            end
         end
         default:
            state_next = CCTC_IDLE;
      endcase
   end

   // port drive decode
   always_comb
   begin
      drv = '0;
      if (meas_reg != 2'h3)
      begin
         drv.sw_a = meas_reg != 2'h1;
         drv.sw_b = meas_reg != 2'h0 || !ext_on;
      end
      drv.res_pre = state_reg == CCTC_PRE;
      if (state_reg == CCTC_PRE || state_reg == CCTC_FULL)
      begin
         drv.drive_0 = drv.sw_a;
         drv.drive_1 = drv.sw_b & ~dc_free;
      end
      if (state_reg == CCTC_DIS || state_reg == CCTC_GND)
      begin
         drv.dis_0 = drv.sw_a;
         drv.dis_1 = drv.sw_b & ~dc_free;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         state_reg <= CCTC_IDLE;
         cnt_reg <= 11'h000;
         meas_reg <= 2'h3;
         tdc_reg <= 16'h0000;
         trig_reg <= 1'b0;
         err_reg <= 1'b0;
         done_reg <= 1'b0;
         raw_reg <= 16'h0000;
         comp_reg <= 16'h0000;
         port_drive <= '0;
         tdc_run <= 1'b0;
         cycle_busy <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         meas_reg <= meas_next;
         tdc_reg <= tdc_next;
         trig_reg <= trig_next;
         err_reg <= err_next;
         done_reg <= done_next;
         raw_reg <= raw_next;
         comp_reg <= comp_next;
         port_drive <= drv;
         tdc_run <= state_next == CCTC_DIS;
         cycle_busy <= state_next != CCTC_IDLE;
      end
   end

   // compensated result, saturating at zero
   always_comb
   begin
      cor_next = cor_reg;
      if (!cfg_reg[CCTC_CFG_CINT])
         cor_next = raw_reg;
      else if (raw_reg > comp_reg)
         cor_next = raw_reg - comp_reg;
      else
         cor_next = 16'h0000;
   end

   // ----------------------------------------
   // AHB-Lite slave, zero wait states
   // ----------------------------------------
   wire take = hsel & hready & htrans[1];
   always_comb
   begin
      wr_pend_next = take & hwrite;
      addr_next = take ? haddr[7:0] : addr_reg;
      cfg_next = cfg_reg;
      pre_next = pre_reg;
      full_next = full_reg;
      dis_next = dis_reg;
      gain_next = gain_reg;
      start_next = 1'b0;
      if (wr_pend_reg)
      begin
         case (addr_reg)
            CCTC_OFF_CFG: cfg_next = hwdata[6:0];
            CCTC_OFF_PRE: pre_next = hwdata[CODE_W-1:0];
            CCTC_OFF_FULL: full_next = hwdata[CODE_W-1:0];
            CCTC_OFF_DIS: dis_next = hwdata[CODE_W-1:0];
            CCTC_OFF_GAIN: gain_next = hwdata[15:0];
            CCTC_OFF_CTRL: start_next = hwdata[CCTC_CTRL_START];
            default: ;
         endcase
      end
      rdata_next = 32'h0000_0000;
      if (take && !hwrite)
      begin
         case (haddr[7:0])
            CCTC_OFF_CFG: rdata_next = {25'h0, cfg_reg};
            CCTC_OFF_PRE: rdata_next = {22'h0, pre_reg};
            CCTC_OFF_FULL: rdata_next = {22'h0, full_reg};
            CCTC_OFF_DIS: rdata_next = {22'h0, dis_reg};
            CCTC_OFF_GAIN: rdata_next = {16'h0, gain_reg};
            CCTC_OFF_STAT: rdata_next = {29'h0, err_reg, done_reg,
               state_reg != CCTC_IDLE};
            CCTC_OFF_RAW: rdata_next = {16'h0, raw_reg};
            CCTC_OFF_COMP: rdata_next = {16'h0, comp_reg};
            CCTC_OFF_COR: rdata_next = {16'h0, cor_reg};
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         wr_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
         cfg_reg <= CCTC_CFG_RST;
         pre_reg <= CCTC_PRE_RST;
         full_reg <= CCTC_FULL_RST;
         dis_reg <= CCTC_DIS_RST;
         gain_reg <= CCTC_GAIN_RST;
         start_reg <= 1'b0;
         cor_reg <= 16'h0000;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         wr_pend_reg <= wr_pend_next;
         addr_reg <= addr_next;
         cfg_reg <= cfg_next;
         pre_reg <= pre_next;
         full_reg <= full_next;
         dis_reg <= dis_next;
         gain_reg <= gain_next;
         start_reg <= start_next;
         cor_reg <= cor_next;
         hrdata <= rdata_next;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_no_full_after_short;
      @(posedge sys_clk) disable iff (!rstn)
      (state_reg == CCTC_GND && !trig_reg) |=> state_reg == CCTC_IDLE;
   endproperty
   a_no_full_after_short: assert property (p_no_full_after_short)
      else $error("short cycle did not stop");
   property p_int_switches_open;
      @(posedge sys_clk) disable iff (!rstn)
      (meas_reg == 2'h3) |=> (!port_drive.sw_a && !port_drive.sw_b);
   endproperty
   a_int_switches_open: assert property (p_int_switches_open)
      else $error("switch closed in internal compensation");
   property p_ext_floating;
      @(posedge sys_clk) disable iff (!rstn)
      (state_reg == CCTC_IDLE && start_reg && !floating)
      |=> meas_reg == 2'h3;
   endproperty
   a_ext_floating: assert property (p_ext_floating)
      else $error("external compensation while grounded");
   property p_comp_sub;
      @(posedge sys_clk) disable iff (!rstn)
      (cfg_reg[CCTC_CFG_CINT] && raw_reg > comp_reg)
      |=> cor_reg == $past(raw_reg) - $past(comp_reg);
   endproperty
   a_comp_sub: assert property (p_comp_sub)
      else $error("internal delay not subtracted");
   property p_slow_base;
      @(posedge sys_clk) disable iff (!rstn)
      (!fast_sel && base_tick) |-> slow_tick;
   endproperty
   a_slow_base: assert property (p_slow_base)
      else $error("slow base tick wrong");
   sequence s_ext_step;
      state_reg == CCTC_GND && trig_reg && meas_reg != 2'h3
         && (meas_reg != 2'h2 || cfg_reg[CCTC_CFG_CINT]);
   endsequence
   property p_meas_order;
      @(posedge sys_clk) disable iff (!rstn)
      s_ext_step |=> meas_reg == $past(meas_reg) + 2'h1;
   endproperty
   a_meas_order: assert property (p_meas_order)
      else $error("floating measurement order broken");
   property p_dc_free_port1;
      @(posedge sys_clk) disable iff (!rstn)
      dc_free |=> (!port_drive.drive_1 && !port_drive.dis_1);
   endproperty
   a_dc_free_port1: assert property (p_dc_free_port1)
      else $error("port 1 driven in dc-free mode");
endmodule

/* tb/cctc_sensor_model.sv */
// cctc_sensor_model: oscillators, electrodes and comparator for the bench
// assumes a 25 MHz sys_clk; every delay is counted in sys_clk cycles
`timescale 1ns/1ps
module cctc_sensor_model
   import cctc_pkg::*;
#(
   parameter int PORT_DLY = 12,
   parameter int INT_DLY = 6
)
(
   input wire logic sys_clk,
   input wire cctc_drive_type port_drive,
   input wire logic tdc_run,
   input wire logic short_mode,
   output logic slow_oscillator,
   output logic fast_oscillator,
   output logic comparator
);
   logic [4:0] slow_cnt = 5'h00;
   logic [1:0] fast_cnt = 2'h0;
   logic [5:0] dis_cnt = 6'h00;
   logic ext;
   initial
   begin
      slow_oscillator = 1'b0;
      fast_oscillator = 1'b0;
      comparator = 1'b0;
   end
   // -----------------------
   // oscillators and sensor
   // -----------------------
   // electrodes add delay over the bare internal path
   assign ext = |{port_drive.sw_a, port_drive.sw_b, port_drive.dis_0,
      port_drive.dis_1};
   always @(posedge sys_clk)
   begin
      // slow period 24 cycles, fast period 4, both phases >= 2
      slow_cnt <= (slow_cnt == 5'h17) ? 5'h00 : slow_cnt + 5'h01;
      slow_oscillator <= slow_cnt < 5'h0C;
      fast_cnt <= fast_cnt + 2'h1;
      fast_oscillator <= fast_cnt[1];
      dis_cnt <= tdc_run ? dis_cnt + {5'h00, dis_cnt != 6'h3F} : 6'h00;
      // a shorted sensor never reaches the trigger level
      comparator <= tdc_run && !short_mode &&
         dis_cnt >= (ext ? PORT_DLY : INT_DLY);
   end
endmodule

/* tb/cctc_top_test.sv */
// cctc_top_test: register level bench of the cycle timing block
// assumes the sensor model supplies oscillators and comparator
`timescale 1ns/1ps
module cctc_top_test
   import cctc_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0, short_mode = 1'b0, tl = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
   logic [31:0] hrdata, q, raw, cmp;
   logic hreadyout, hresp, slow_oscillator, fast_oscillator, comparator;
   logic tdc_run, cycle_busy;
   logic [1:0] dp = 2'h0;
   logic [5:0] pat = 6'h00;
   cctc_drive_type port_drive;
   int n_mismatch = 0, check_count = 0;
   int npre = 0, nfull = 0, ndis = 0, pulses = 0, swon = 0, d1 = 0;
   logic [7:0] ra [6] = '{CCTC_OFF_CFG, CCTC_OFF_PRE, CCTC_OFF_FULL,
      CCTC_OFF_DIS, CCTC_OFF_GAIN, 8'h30};
   logic [31:0] rv [6] = '{32'(CCTC_CFG_RST), 32'(CCTC_PRE_RST),
      32'(CCTC_FULL_RST), 32'(CCTC_DIS_RST), 32'(CCTC_GAIN_RST),
      32'h0000_0000};

   cctc_top i_cctc_top (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp),
      .slow_oscillator(slow_oscillator), .fast_oscillator(fast_oscillator),
      .comparator(comparator), .port_drive(port_drive), .tdc_run(tdc_run),
      .cycle_busy(cycle_busy));
   cctc_sensor_model i_cctc_sensor_model (.sys_clk(sys_clk),
      .port_drive(port_drive), .tdc_run(tdc_run), .short_mode(short_mode),
      .slow_oscillator(slow_oscillator), .fast_oscillator(fast_oscillator),
      .comparator(comparator));

   initial
   begin
      forever #20 sys_clk = ~sys_clk;
   end
   // -----------------------
   // port monitor
   // -----------------------
   // phase lengths are taken from the first cycle of a sequence only
   always @(posedge sys_clk)
   begin
      tl <= tdc_run;
      if (port_drive.res_pre)
         dp <= {port_drive.drive_0, port_drive.drive_1};
      if (port_drive.res_pre && pulses == 0)
         npre++;
      // drive lags the state by one cycle, tdc_run does not; tl aligns them
      if (npre > 0 && pulses == 0 && !port_drive.res_pre && !tl)
         nfull++;
      if (tdc_run && !tl)
      begin
         pulses++;
         pat <= {pat[3:0], dp};
      end
      if (tdc_run && pulses == 1)
         ndis++;
      if (tdc_run && (port_drive.sw_a || port_drive.sw_b))
         swon++;
      if (port_drive.drive_1)
         d1++;
   end
   // -----------------------
   // tasks
   // -----------------------
   task automatic stop_test();
      if (n_mismatch == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, s);
      check_count++;
      if (s !== e)
      begin
         $display("unexpected %s: expected %h seen %h", n, e, s);
         n_mismatch++;
      end
   endtask

   // zero wait slave, but the wait loops stay in case it stretches
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic run(input logic [6:0] c, input logic [9:0] p, f, d);
      int i;
      bus(1'b1, CCTC_OFF_CFG, 32'(c));
      bus(1'b1, CCTC_OFF_PRE, 32'(p));
      bus(1'b1, CCTC_OFF_FULL, 32'(f));
      bus(1'b1, CCTC_OFF_DIS, 32'(d));
      npre = 0;
      nfull = 0;
      ndis = 0;
      pulses = 0;
      swon = 0;
      d1 = 0;
      bus(1'b1, CCTC_OFF_CTRL, 32'h0000_0001);
      i = 0;
      while (cycle_busy !== 1'b1 && i < 20)
      begin
         @(posedge sys_clk);
         i++;
      end
      while (cycle_busy !== 1'b0)
         @(posedge sys_clk);
   endtask

   task automatic timing(input logic [6:0] c, input logic [9:0] p, f, d);
      int per, ep, ef, ed;
      per = c[CCTC_CFG_FAST] ? (c[CCTC_CFG_BYP] ? 4 : 16) : 24;
      ep = (p == CCTC_CODE_SKIP) ? 0 :
         (p + ((c[CCTC_CFG_FAST] && f == CCTC_CODE_SKIP) ? 2 : 1)) * per;
      ef = (f == CCTC_CODE_SKIP) ? 0 : (f + (c[CCTC_CFG_FAST] ? 2 : 1)) * per;
      ed = (d + (c[CCTC_CFG_FAST] ? 0 : 1)) * per;
      run(c, p, f, d);
      // pre-charge starts off tick, so its first period may be short
      chk("pre", 1, ep == 0 ? npre == 0 : npre > ep - per && npre <= ep);
      if (p != CCTC_CODE_SKIP)
         chk("full", ef, nfull);
      chk("discharge", ed, ndis);
   endtask
   // -----------------------
   // main sequence
   // -----------------------
   initial
   begin
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      bus(1'b1, 8'h30, 32'hFFFF_FFFF);
      for (int i = 0; i < 6; i++)
      begin
         bus(1'b0, ra[i], 32'h0000_0000);
         chk("reset value", rv[i], q);
      end
      chk("hresp", 32'h0000_0000, 32'(hresp));
      bus(1'b1, CCTC_OFF_GAIN, 32'h0000_0040);
      bus(1'b0, CCTC_OFF_GAIN, 32'h0000_0000);
      chk("gain", 32'h0000_0040, q);
      timing(7'h00, 10'h002, 10'h001, 10'h003);
      timing(7'h01, 10'h000, 10'h000, 10'h002);
      timing(7'h03, 10'h001, 10'h3FF, 10'h005);
      timing(7'h00, 10'h3FF, 10'h002, 10'h000);
      run(7'h30, 10'h001, 10'h001, 10'h003);
      chk("grounded cycles", 1, pulses);
      chk("switches closed", 0, swon);
      run(7'h27, 10'h001, 10'h001, 10'h005);
      chk("port order", 6'b10_01_11, pat);
      run(7'h37, 10'h001, 10'h001, 10'h005);
      chk("floating cycles", 4, pulses);
      bus(1'b0, CCTC_OFF_RAW, 32'h0000_0000);
      raw = q;
      bus(1'b0, CCTC_OFF_COMP, 32'h0000_0000);
      cmp = q;
      bus(1'b0, CCTC_OFF_COR, 32'h0000_0000);
      chk("corrected", raw - cmp, q);
      run(7'h6F, 10'h001, 10'h001, 10'h005);
      chk("port 1 drive", 0, d1);
      short_mode <= 1'b1;
      run(7'h27, 10'h001, 10'h001, 10'h005);
      chk("short cycles", 1, pulses);
      bus(1'b0, CCTC_OFF_STAT, 32'h0000_0000);
      chk("short flag", 1, 32'(q[2]));
      short_mode <= 1'b0;
      stop_test();
   end

   initial
   begin
      repeat (60000) @(posedge sys_clk);
      n_mismatch++;
      stop_test();
   end
endmodule
